// *** hdl/tone_comp_pkg.sv ***
package tone_comp_pkg;

    typedef logic [7:0] reg_byte_t;

    // Register addresses
    localparam reg_byte_t ADDR_COMP_ENABLE_THRESHOLD = 8'h44;
    localparam reg_byte_t ADDR_COMP_HOLD = 8'h45;
    localparam reg_byte_t ADDR_COMP_ATTACK_DECAY = 8'h46;
    localparam reg_byte_t ADDR_LEFT_TONE_ENABLE_VOLUME = 8'h47;
    localparam reg_byte_t ADDR_TONE_LENGTH_HI = 8'h49;
    localparam reg_byte_t ADDR_TONE_LENGTH_MID = 8'h4A;
    localparam reg_byte_t ADDR_TONE_LENGTH_LO = 8'h4B;
    localparam reg_byte_t ADDR_TONE_SINE_HI = 8'h4C;
    localparam reg_byte_t ADDR_TONE_SINE_LO = 8'h4D;
    localparam reg_byte_t ADDR_TONE_COSINE_HI = 8'h4E;
    localparam reg_byte_t ADDR_TONE_COSINE_LO = 8'h4F;

    // Reset values
    localparam reg_byte_t RST_COMP_ENABLE_THRESHOLD = 8'h0F;
    localparam logic [3:0] RST_HOLD_CODE = 4'h7;
    localparam reg_byte_t RST_COMP_ATTACK_DECAY = 8'h00;
    localparam reg_byte_t RST_LEFT_TONE = 8'h00;
    localparam logic [23:0] RST_TONE_LENGTH = 24'h0000EE;
    localparam logic [15:0] RST_TONE_SINE = 16'h10D8;
    localparam logic [15:0] RST_TONE_COSINE = 16'h7EE3;

    // Field positions
    localparam int BIT_RSVD_TOP = 7;
    localparam int BIT_LEFT_COMP_EN = 6;
    localparam int BIT_RIGHT_COMP_EN = 5;
    localparam int THR_LSB = 2;
    localparam int HOLD_LSB = 3;
    localparam int ATTACK_LSB = 4;
    localparam int BIT_TONE_EN = 7;
    localparam int BIT_TONE_RSVD = 6;

    // Hold timing in DAC word clocks
    localparam logic [17:0] HOLD_BASE_WORDS = 18'h00020;
    localparam logic [17:0] HOLD_LONG_UNIT = 18'h08000;
    localparam logic [3:0] HOLD_CODE_OFF = 4'h0;
    localparam logic [3:0] HOLD_CODE_X4 = 4'hE;
    localparam logic [3:0] HOLD_CODE_X5 = 4'hF;
    localparam int HOLD_MULT_X4 = 4;
    localparam int HOLD_MULT_X5 = 5;

    // Gain reduction in dB, unsigned with 24 fraction bits
    localparam int FRAC_BITS = 24;
    localparam logic [31:0] ATTACK_BASE = 32'h0400_0000;
    localparam logic [31:0] DECAY_BASE = 32'h0004_0000;
    localparam logic [31:0] GAIN_REDUCTION_MAX = 32'h4000_0000;

    // Threshold: -(code+1)*3 dB
    localparam logic [6:0] THR_STEP_DB = 7'h03;
    localparam int LEVEL_W = 7;

    // Tone oscillator
    localparam int COEF_FRAC = 15;
    localparam logic signed [15:0] OSC_START_X = 16'sh7FFF;

    typedef enum logic [3:0]
    {
        ST_STEADY = 4'b0001,
        ST_ATTACK = 4'b0010,
        ST_HOLD = 4'b0100,
        ST_DECAY = 4'b1000
    } comp_state_t;

endpackage

// *** hdl/comp_cfg_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface comp_cfg_if;
    logic [2:0] thrCode;
    logic [1:0] hystCode;
    logic [3:0] holdCode;
    logic [3:0] attackCode;
    logic [3:0] decayCode;

    modport ctrl
    (
        output thrCode,
        output hystCode,
        output holdCode,
        output attackCode,
        output decayCode
    );

    modport comp
    (
        input thrCode,
        input hystCode,
        input holdCode,
        input attackCode,
        input decayCode
    );
endinterface
`default_nettype wire

// *** hdl/comp_channel.sv ***
`timescale 1ns/1ps
`default_nettype none
module comp_channel
(
    // Clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // Word clock and signal level
    input wire logic wordTick,
    input wire logic chanEnable,
    input wire logic [tone_comp_pkg::LEVEL_W-1:0] levelDb,
    // Shared settings
    comp_cfg_if.comp cfg,
    // Gain reduction state
    output logic [31:0] gainReduction,
    output logic compressing
);
    import tone_comp_pkg::*;

    function automatic logic [17:0] holdWords(input logic [3:0] code);
        logic [17:0] w;
        w = '0;
        case (code)
            HOLD_CODE_OFF: w = '0;
            HOLD_CODE_X4: w = 18'(HOLD_LONG_UNIT * HOLD_MULT_X4);
            HOLD_CODE_X5: w = 18'(HOLD_LONG_UNIT * HOLD_MULT_X5);
            default: w = HOLD_BASE_WORDS << (code - 4'h1);
        endcase
        return w;
    endfunction

    comp_state_t state_q, state_d;
    logic [31:0] acc_q, acc_d;
    logic [17:0] holdCnt_q, holdCnt_d;
    logic [6:0] thrDb;
    logic [6:0] releaseDb;
    logic overThr;
    logic belowRelease;
    logic [31:0] attackStep;
    logic [31:0] decayStep;
    logic [31:0] decayed;

    // Level is dB below full scale, so larger means quieter
    assign thrDb = 7'(THR_STEP_DB * ({4'h0, cfg.thrCode} + 7'h01));
    assign releaseDb = thrDb + {5'h00, cfg.hystCode};
    assign overThr = levelDb < thrDb;
    assign belowRelease = levelDb > releaseDb;
    assign attackStep = ATTACK_BASE >> cfg.attackCode;
    assign decayStep = DECAY_BASE >> cfg.decayCode;
    assign decayed = (acc_q < decayStep) ? '0 : acc_q - decayStep;

    always_comb
    begin
        state_d = state_q;
        acc_d = acc_q;
        holdCnt_d = holdCnt_q;
        if (!chanEnable)
        begin
            // Disabled channel passes at unity gain
            state_d = ST_STEADY;
            acc_d = '0;
            holdCnt_d = '0;
        end
        else if (wordTick)
        begin
            if (overThr)
            begin
                state_d = ST_ATTACK;
                acc_d = (GAIN_REDUCTION_MAX - acc_q < attackStep) ? GAIN_REDUCTION_MAX : acc_q + attackStep;
            end
            else if (belowRelease && acc_q != '0)
            begin
                case (state_q)
                    ST_HOLD:
                    begin
                        holdCnt_d = holdCnt_q - 18'h00001;
                        if (holdCnt_q <= 18'h00001)
                        begin
                            state_d = ST_DECAY;
                        end
                    end
                    ST_DECAY:
                    begin
                        acc_d = decayed;
                        if (acc_q <= decayStep)
                        begin
                            state_d = ST_STEADY;
                        end
                    end
                    default:
                    begin
                        holdCnt_d = holdWords(cfg.holdCode);
                        state_d = ST_HOLD;
                        if (cfg.holdCode == HOLD_CODE_OFF)
                        begin
                            // No hold: decay starts on the first release tick
                            acc_d = decayed;
                            state_d = (acc_q <= decayStep) ? ST_STEADY : ST_DECAY;
                        end
                    end
                endcase
            end
            else
            begin
                // Inside the hysteresis band the gain is frozen and hold restarts later
                state_d = ST_STEADY;
            end
        end
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_q <= ST_STEADY;
            acc_q <= '0;
            holdCnt_q <= '0;
        end
        else
        begin
            state_q <= state_d;
            acc_q <= acc_d;
            holdCnt_q <= holdCnt_d;
        end
    end

    assign gainReduction = acc_q;
    assign compressing = (acc_q != '0);

endmodule // comp_channel
`default_nettype wire

// *** hdl/tone_comp_regs.sv ***
`timescale 1ns/1ps
`default_nettype none
module tone_comp_regs
(
    // Clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // Register access from the serial control bus
    input wire logic regWrite,
    input wire logic regRead,
    input wire tone_comp_pkg::reg_byte_t regAddr,
    input wire tone_comp_pkg::reg_byte_t regWrData,
    output tone_comp_pkg::reg_byte_t regRdData,
    // DAC timing and mode
    input wire logic dacWordTick,
    input wire logic toneCapableProcessingConfig,
    // Channel levels in dB below full scale
    input wire logic [tone_comp_pkg::LEVEL_W-1:0] levelLeftDb,
    input wire logic [tone_comp_pkg::LEVEL_W-1:0] levelRightDb,
    // Compressor results
    output logic [31:0] gainReductionLeft,
    output logic [31:0] gainReductionRight,
    output logic forceIndependentVolume,
    // Tone generator
    output logic toneActive,
    output logic signed [15:0] toneSample,
    output logic [5:0] toneLeftVolume
);
    import tone_comp_pkg::*;

    reg_byte_t enThr_q, enThr_d;
    logic [3:0] holdCode_q, holdCode_d;
    reg_byte_t atkDec_q, atkDec_d;
    logic toneEn_q, toneEn_d;
    logic toneRsvd_q, toneRsvd_d;
    logic [5:0] toneVol_q, toneVol_d;
    logic [23:0] toneLen_q, toneLen_d;
    logic [15:0] toneSin_q, toneSin_d;
    logic [15:0] toneCos_q, toneCos_d;
    reg_byte_t rdData_q, rdData_d;
    logic [23:0] remain_q, remain_d;
    logic signed [15:0] oscX_q, oscX_d;
    logic signed [15:0] oscY_q, oscY_d;
    logic toneActive_q, toneActive_d;
    logic signed [15:0] toneSample_q, toneSample_d;
    logic forceIndep_q, forceIndep_d;
    logic [1:0] chanEn;
    logic [LEVEL_W-1:0] chanLevel [2];
    logic [31:0] chanGr [2];
    logic [31:0] grOut_q [2];
    logic signed [31:0] prodCx;
    logic signed [31:0] prodSy;
    logic signed [31:0] prodSx;
    logic signed [31:0] prodCy;
    logic signed [32:0] sumX;
    logic signed [32:0] sumY;
    logic wrHit;
    logic toneRun;

    comp_cfg_if cfgBus ();

    // Register writes
    always_comb
    begin
        enThr_d = enThr_q;
        holdCode_d = holdCode_q;
        atkDec_d = atkDec_q;
        toneRsvd_d = toneRsvd_q;
        toneVol_d = toneVol_q;
        toneLen_d = toneLen_q;
        toneSin_d = toneSin_q;
        toneCos_d = toneCos_q;
        wrHit = 1'b0;
        if (regWrite)
        begin
            case (regAddr)
                ADDR_COMP_ENABLE_THRESHOLD: enThr_d = regWrData;
                ADDR_COMP_HOLD: holdCode_d = regWrData[HOLD_LSB +: 4];
                ADDR_COMP_ATTACK_DECAY: atkDec_d = regWrData;
                ADDR_LEFT_TONE_ENABLE_VOLUME:
                begin
                    wrHit = 1'b1;
                    toneRsvd_d = regWrData[BIT_TONE_RSVD];
                    toneVol_d = regWrData[5:0];
                end
                ADDR_TONE_LENGTH_HI: toneLen_d[23:16] = regWrData;
                ADDR_TONE_LENGTH_MID: toneLen_d[15:8] = regWrData;
                ADDR_TONE_LENGTH_LO: toneLen_d[7:0] = regWrData;
                ADDR_TONE_SINE_HI: toneSin_d[15:8] = regWrData;
                ADDR_TONE_SINE_LO: toneSin_d[7:0] = regWrData;
                ADDR_TONE_COSINE_HI: toneCos_d[15:8] = regWrData;
                ADDR_TONE_COSINE_LO: toneCos_d[7:0] = regWrData;
                default: wrHit = 1'b0;
            endcase
        end
    end

    // Register reads, answered on the next edge
    always_comb
    begin
        rdData_d = rdData_q;
        if (regRead)
        begin
            case (regAddr)
                ADDR_COMP_ENABLE_THRESHOLD: rdData_d = enThr_q;
                ADDR_COMP_HOLD: rdData_d = {1'b0, holdCode_q, 3'b000};
                ADDR_COMP_ATTACK_DECAY: rdData_d = atkDec_q;
                ADDR_LEFT_TONE_ENABLE_VOLUME: rdData_d = {toneEn_q, toneRsvd_q, toneVol_q};
                ADDR_TONE_LENGTH_HI: rdData_d = toneLen_q[23:16];
                ADDR_TONE_LENGTH_MID: rdData_d = toneLen_q[15:8];
                ADDR_TONE_LENGTH_LO: rdData_d = toneLen_q[7:0];
                ADDR_TONE_SINE_HI: rdData_d = toneSin_q[15:8];
                ADDR_TONE_SINE_LO: rdData_d = toneSin_q[7:0];
                ADDR_TONE_COSINE_HI: rdData_d = toneCos_q[15:8];
                ADDR_TONE_COSINE_LO: rdData_d = toneCos_q[7:0];
                default: rdData_d = 8'h00;
            endcase
        end
    end

    // Quadrature oscillator products in Q15
    assign prodCx = $signed(toneCos_q) * oscX_q;
    assign prodSy = $signed(toneSin_q) * oscY_q;
    assign prodSx = $signed(toneSin_q) * oscX_q;
    assign prodCy = $signed(toneCos_q) * oscY_q;
    assign sumX = 33'(prodCx) - 33'(prodSy);
    assign sumY = 33'(prodSx) + 33'(prodCy);

    // Tone runs only in the tone-capable processing configuration
    assign toneRun = toneEn_q && toneCapableProcessingConfig;

    // Tone sequencing
    always_comb
    begin
        toneEn_d = toneEn_q;
        remain_d = remain_q;
        oscX_d = oscX_q;
        oscY_d = oscY_q;
        toneSample_d = toneSample_q;
        if (wrHit)
        begin
            // A software write wins over a same-cycle expiry
            toneEn_d = regWrData[BIT_TONE_EN];
            remain_d = toneLen_d;
            oscX_d = OSC_START_X;
            oscY_d = '0;
        end
        else if (toneRun && dacWordTick)
        begin
            remain_d = (remain_q == '0) ? '0 : remain_q - 24'h000001;
            if (remain_q <= 24'h000001)
            begin
                toneEn_d = 1'b0;
            end
            oscX_d = sumX[COEF_FRAC +: 16];
            oscY_d = sumY[COEF_FRAC +: 16];
            toneSample_d = oscY_q;
        end
        if (!toneRun)
        begin
            toneSample_d = '0;
        end
    end

    assign toneActive_d = toneRun;
    assign forceIndep_d = enThr_q[BIT_LEFT_COMP_EN] | enThr_q[BIT_RIGHT_COMP_EN];

    // Configuration registers
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            enThr_q <= RST_COMP_ENABLE_THRESHOLD;
            holdCode_q <= RST_HOLD_CODE;
            atkDec_q <= RST_COMP_ATTACK_DECAY;
            toneRsvd_q <= RST_LEFT_TONE[BIT_TONE_RSVD];
            toneVol_q <= RST_LEFT_TONE[5:0];
            toneLen_q <= RST_TONE_LENGTH;
            toneSin_q <= RST_TONE_SINE;
            toneCos_q <= RST_TONE_COSINE;
        end
        else
        begin
            enThr_q <= enThr_d;
            holdCode_q <= holdCode_d;
            atkDec_q <= atkDec_d;
            toneRsvd_q <= toneRsvd_d;
            toneVol_q <= toneVol_d;
            toneLen_q <= toneLen_d;
            toneSin_q <= toneSin_d;
            toneCos_q <= toneCos_d;
        end
    end

    // Read data
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rdData_q <= '0;
        end
        else
        begin
            rdData_q <= rdData_d;
        end
    end

    // Tone state and status flags
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            toneEn_q <= RST_LEFT_TONE[BIT_TONE_EN];
            remain_q <= '0;
            oscX_q <= OSC_START_X;
            oscY_q <= '0;
            toneActive_q <= 1'b0;
            toneSample_q <= '0;
            forceIndep_q <= 1'b0;
        end
        else
        begin
            toneEn_q <= toneEn_d;
            remain_q <= remain_d;
            oscX_q <= oscX_d;
            oscY_q <= oscY_d;
            toneActive_q <= toneActive_d;
            toneSample_q <= toneSample_d;
            forceIndep_q <= forceIndep_d;
        end
    end

    // Compressor settings shared by both channels
    assign cfgBus.thrCode = enThr_q[THR_LSB +: 3];
    assign cfgBus.hystCode = enThr_q[1:0];
    assign cfgBus.holdCode = holdCode_q;
    assign cfgBus.attackCode = atkDec_q[ATTACK_LSB +: 4];
    assign cfgBus.decayCode = atkDec_q[3:0];

    assign chanEn[0] = enThr_q[BIT_LEFT_COMP_EN];
    assign chanEn[1] = enThr_q[BIT_RIGHT_COMP_EN];
    assign chanLevel[0] = levelLeftDb;
    assign chanLevel[1] = levelRightDb;

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++)
        begin : g_chan
            comp_channel u_comp
            (
                .mclk(mclk),
                .arst_n(arst_n),
                .wordTick(dacWordTick),
                .chanEnable(chanEn[ch]),
                .levelDb(chanLevel[ch]),
                .cfg(cfgBus.comp),
                .gainReduction(chanGr[ch]),
                .compressing()
            );

            // Extra stage keeps the top outputs on local flops
            always_ff @(posedge mclk or negedge arst_n)
            begin
                if (!arst_n)
                begin
                    grOut_q[ch] <= '0;
                end
                else
                begin
                    grOut_q[ch] <= chanGr[ch];
                end
            end
        end
    endgenerate

    assign regRdData = rdData_q;
    assign gainReductionLeft = grOut_q[0];
    assign gainReductionRight = grOut_q[1];
    assign forceIndependentVolume = forceIndep_q;
    assign toneActive = toneActive_q;
    assign toneSample = toneSample_q;
    assign toneLeftVolume = toneVol_q;

endmodule // tone_comp_regs
`default_nettype wire

// *** tb/tone_comp_regs_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
module tone_comp_regs_asserts
(
    // Clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // Register bus
    input wire logic regWrite,
    input wire logic regRead,
    input wire tone_comp_pkg::reg_byte_t regAddr,
    input wire tone_comp_pkg::reg_byte_t regWrData,
    input wire tone_comp_pkg::reg_byte_t regRdData,
    // Timing and mode
    input wire logic dacWordTick,
    input wire logic toneCapableProcessingConfig,
    // Results
    input wire logic [31:0] gainReductionLeft,
    input wire logic [31:0] gainReductionRight,
    input wire logic forceIndependentVolume,
    input wire logic toneActive,
    input wire logic signed [15:0] toneSample,
    input wire logic [5:0] toneLeftVolume
);
    import tone_comp_pkg::*;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!arst_n);
    wire logic volWrite = regWrite && regAddr == ADDR_LEFT_TONE_ENABLE_VOLUME;
    wire logic unmapped = !(regAddr inside {[8'h44:8'h47], [8'h49:8'h4F]});

    // Volume copy lags one edge, and two quiet edges are waited out
    sequence s_vol_quiet;
        !volWrite [*2];
    endsequence
    sequence s_tone_idle;
        !toneActive [*2];
    endsequence
    property p_vol_follow;
        logic [5:0] v;
        (volWrite, v = regWrData[5:0]) ##1 s_vol_quiet |-> toneLeftVolume == v;
    endproperty

    a_vol_field_follows: assert property (p_vol_follow)
        else $error("tone volume does not follow register");
    a_tone_needs_config: assert property (!$past(toneCapableProcessingConfig) |-> !toneActive)
        else $error("tone active without capable config");
    a_tone_starts: assert property (volWrite && regWrData[7] ##1 toneCapableProcessingConfig |-> ##1 toneActive)
        else $error("tone did not start");
    a_idle_silent: assert property (s_tone_idle |-> toneSample == 16'sh0000)
        else $error("tone sample while idle");
    a_unmapped_reads_zero: assert property (regRead && unmapped |=> regRdData == 8'h00)
        else $error("unmapped read not zero");
    a_hold_rsvd_zero: assert property (regRead && regAddr == ADDR_COMP_HOLD |=> (regRdData & 8'h87) == 8'h00)
        else $error("hold register reserved bits set");
    a_gain_cleared: assert property ((!forceIndependentVolume) [*3] |->
        gainReductionLeft == 32'h0 && gainReductionRight == 32'h0)
        else $error("gain reduction with compression off");
    a_gain_capped: assert property (gainReductionLeft <= GAIN_REDUCTION_MAX
        && gainReductionRight <= GAIN_REDUCTION_MAX)
        else $error("gain reduction above cap");
    a_attack_bounded: assert property (gainReductionLeft > $past(gainReductionLeft) |->
        gainReductionLeft - $past(gainReductionLeft) <= ATTACK_BASE
        && ($past(dacWordTick) || $past(dacWordTick, 2)))
        else $error("attack step too large or without word tick");
endmodule // tone_comp_regs_asserts

bind tone_comp_regs tone_comp_regs_asserts i_asserts
(
    .mclk,
    .arst_n,
    .regWrite,
    .regRead,
    .regAddr,
    .regWrData,
    .regRdData,
    .dacWordTick,
    .toneCapableProcessingConfig,
    .gainReductionLeft,
    .gainReductionRight,
    .forceIndependentVolume,
    .toneActive,
    .toneSample,
    .toneLeftVolume
);
`default_nettype wire

// *** tb/tb_playback_compressor_beep_control.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_playback_compressor_beep_control;
    import tone_comp_pkg::*;
    logic mclk;
    logic arst_n;
    logic wrEn;
    logic rdEn;
    reg_byte_t addr;
    reg_byte_t wrData;
    reg_byte_t rdData;
    logic tick;
    logic cfgOk;
    logic [LEVEL_W-1:0] lvlL;
    logic [LEVEL_W-1:0] lvlR;
    logic [31:0] gainL;
    logic [31:0] gainR;
    logic indep;
    logic active;
    logic signed [15:0] sample;
    logic [5:0] vol;
    logic [31:0] expGain;
    int n_fail = 0;
    int n_tests = 0;
    int cycles = 0;
    // Address, reset value, value written, value read back
    reg_byte_t rows [0:12][0:3] = '{'{8'h44, 8'h0F, 8'h70, 8'h70}, '{8'h45, 8'h38, 8'h78, 8'h78},
        '{8'h46, 8'h00, 8'hA5, 8'hA5}, '{8'h47, 8'h00, 8'h3F, 8'h3F}, '{8'h48, 8'h00, 8'hFF, 8'h00},
        '{8'h49, 8'h00, 8'h12, 8'h12}, '{8'h4A, 8'h00, 8'h34, 8'h34}, '{8'h4B, 8'hEE, 8'h56, 8'h56},
        '{8'h4C, 8'h10, 8'h9A, 8'h9A}, '{8'h4D, 8'hD8, 8'hBC, 8'hBC}, '{8'h4E, 8'h7E, 8'hDE, 8'hDE},
        '{8'h4F, 8'hE3, 8'hF0, 8'hF0}, '{8'h50, 8'h00, 8'hFF, 8'h00}};

    tone_comp_regs i_dut
    (
        .mclk(mclk),
        .arst_n(arst_n),
        .regWrite(wrEn),
        .regRead(rdEn),
        .regAddr(addr),
        .regWrData(wrData),
        .regRdData(rdData),
        .dacWordTick(tick),
        .toneCapableProcessingConfig(cfgOk),
        .levelLeftDb(lvlL),
        .levelRightDb(lvlR),
        .gainReductionLeft(gainL),
        .gainReductionRight(gainR),
        .forceIndependentVolume(indep),
        .toneActive(active),
        .toneSample(sample),
        .toneLeftVolume(vol)
    );

    initial
    begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    task automatic give_verdict();
        if (n_fail == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Run is under a thousand cycles
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            n_fail++;
            give_verdict();
        end
    end

    task automatic chk8(input reg_byte_t got, input reg_byte_t exp);
        n_tests++;
        if (got !== exp)
        begin
            n_fail++;
            $display("unexpected at %0t: byte %h, want %h", $time, got, exp);
        end
    endtask

    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_fail++;
            $display("unexpected at %0t: gain %h, want %h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        n_tests++;
        if (got !== exp)
        begin
            n_fail++;
            $display("unexpected at %0t: flag %b, want %b", $time, got, exp);
        end
    endtask

    // Inputs always change 1 ns after the rising edge
    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    // Idle edge first, so a strobe never falls and rises in one time step
    task automatic wr(input reg_byte_t a, input reg_byte_t d);
        step(1);
        wrEn = 1'b1;
        addr = a;
        wrData = d;
        step(1);
        wrEn = 1'b0;
    endtask

    task automatic rd(input reg_byte_t a, input reg_byte_t e);
        step(1);
        rdEn = 1'b1;
        addr = a;
        step(1);
        rdEn = 1'b0;
        chk8(rdData, e);
    endtask

    // Back-to-back word ticks, then room for the output lag
    task automatic ticks(input int n);
        tick = 1'b1;
        step(n);
        tick = 1'b0;
        step(2);
    endtask

    initial
    begin
        arst_n = 1'b0;
        wrEn = 1'b0;
        rdEn = 1'b0;
        addr = 8'h00;
        wrData = 8'h00;
        tick = 1'b0;
        cfgOk = 1'b1;
        lvlL = 7'h7F;
        lvlR = 7'h7F;
        step(12);
        arst_n = 1'b1;
        step(1);
        foreach (rows[i])
        begin
            rd(rows[i][0], rows[i][1]);
            wr(rows[i][0], rows[i][2]);
            rd(rows[i][0], rows[i][3]);
        end
        arst_n = 1'b0;
        step(2);
        arst_n = 1'b1;
        step(1);
        rd(ADDR_COMP_HOLD, 8'h38);
        wr(ADDR_TONE_LENGTH_LO, 8'h03);
        wr(ADDR_LEFT_TONE_ENABLE_VOLUME, 8'h85);
        chk1(active, 1'b0);
        step(1);
        chk1(active, 1'b1);
        chk8({2'b00, vol}, 8'h05);
        ticks(2);
        chk1(active, 1'b1);
        chk1(sample != 16'sh0000, 1'b1);
        ticks(1);
        chk1(active, 1'b0);
        chk1(sample == 16'sh0000, 1'b1);
        rd(ADDR_LEFT_TONE_ENABLE_VOLUME, 8'h05);
        cfgOk = 1'b0;
        wr(ADDR_LEFT_TONE_ENABLE_VOLUME, 8'h81);
        ticks(5);
        chk1(active, 1'b0);
        rd(ADDR_LEFT_TONE_ENABLE_VOLUME, 8'h81);
        cfgOk = 1'b1;
        step(2);
        chk1(active, 1'b1);
        wr(ADDR_LEFT_TONE_ENABLE_VOLUME, 8'h01);
        step(1);
        chk1(active, 1'b0);
        wr(ADDR_TONE_LENGTH_MID, 8'h01);
        wr(ADDR_TONE_LENGTH_LO, 8'h00);
        wr(ADDR_LEFT_TONE_ENABLE_VOLUME, 8'h81);
        ticks(255);
        chk1(active, 1'b1);
        ticks(1);
        chk1(active, 1'b0);
        lvlL = 7'h00;
        lvlR = 7'h00;
        wr(ADDR_COMP_ENABLE_THRESHOLD, 8'h4F);
        ticks(1);
        chk32(gainL, ATTACK_BASE);
        chk32(gainR, 32'h0);
        chk1(indep, 1'b1);
        expGain = ATTACK_BASE;
        wr(ADDR_COMP_ATTACK_DECAY, 8'h40);
        for (int c = 0; c < 8; c++)
        begin
            wr(ADDR_COMP_ENABLE_THRESHOLD, 8'h43 | reg_byte_t'(c << 2));
            lvlL = 7'(3 * c + 2);
            ticks(1);
            expGain += ATTACK_BASE >> 4;
            chk32(gainL, expGain);
            lvlL = 7'(3 * c + 3);
            ticks(1);
            chk32(gainL, expGain);
        end
        wr(ADDR_COMP_ENABLE_THRESHOLD, 8'h4E);
        wr(ADDR_COMP_HOLD, 8'h00);
        wr(ADDR_COMP_ATTACK_DECAY, 8'h42);
        lvlL = 7'h0E;
        ticks(1);
        chk32(gainL, expGain);
        lvlL = 7'h0F;
        ticks(1);
        expGain -= DECAY_BASE >> 2;
        chk32(gainL, expGain);
        wr(ADDR_COMP_HOLD, 8'h08);
        lvlL = 7'h00;
        ticks(1);
        expGain += ATTACK_BASE >> 4;
        lvlL = 7'h14;
        ticks(31);
        chk32(gainL, expGain);
        ticks(8);
        chk1(gainL < expGain && gainL >= expGain - 8 * (DECAY_BASE >> 2), 1'b1);
        wr(ADDR_COMP_ENABLE_THRESHOLD, 8'h2F);
        ticks(1);
        chk32(gainL, 32'h0);
        chk32(gainR, ATTACK_BASE >> 4);
        wr(ADDR_COMP_ENABLE_THRESHOLD, 8'h0F);
        step(3);
        chk32(gainR, 32'h0);
        chk1(indep, 1'b0);
        give_verdict();
    end
endmodule // tb_playback_compressor_beep_control
`default_nettype wire
